/* hw/rhpcf_pkg.sv */
package rhpcf_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned RHPCF_CLK_HZ = 40_000_000;
  localparam int unsigned RHPCF_CYC_PER_MS = RHPCF_CLK_HZ / 1000;
  localparam int unsigned RHPCF_RESET_TIME_MS = 10;
  localparam int unsigned RHPCF_RESYNC_TIME_MS = 3;
  localparam int unsigned RHPCF_RESET_CYCLES =
    RHPCF_RESET_TIME_MS * RHPCF_CYC_PER_MS;
  localparam int unsigned RHPCF_RESYNC_CYCLES =
    RHPCF_RESYNC_TIME_MS * RHPCF_CYC_PER_MS;

  // ---------------------------------------------------------------
  // command codes, port one; port two is one higher
  // ---------------------------------------------------------------
  localparam logic [7:0] RHPCF_RD_CODE_BASE = 8'h15;
  localparam logic [7:0] RHPCF_WR_CODE_BASE = 8'h95;
  localparam int unsigned RHPCF_MAX_PORTS = 2;

  // ---------------------------------------------------------------
  // lower word field positions
  // ---------------------------------------------------------------
  localparam int unsigned RHPCF_ATTACHED_BIT = 0;
  localparam int unsigned RHPCF_ENABLED_BIT = 1;
  localparam int unsigned RHPCF_SLEEP_BIT = 2;
  localparam int unsigned RHPCF_OC_LEVEL_BIT = 3;
  localparam int unsigned RHPCF_RESET_BIT = 4;

  // ---------------------------------------------------------------
  // change flags: upper word bits 16 to 20
  // ---------------------------------------------------------------
  localparam int unsigned RHPCF_FLAG_BASE = 16;
  localparam int unsigned RHPCF_FLAG_W = 5;
  localparam int unsigned RHPCF_F_ATTACH = 0;
  localparam int unsigned RHPCF_F_ENABLE = 1;
  localparam int unsigned RHPCF_F_RESUME = 2;
  localparam int unsigned RHPCF_F_OC = 3;
  localparam int unsigned RHPCF_F_RESET = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [RHPCF_FLAG_W-1:0] RHPCF_FLAGS_RST = 5'h00;
  localparam logic [31:0] RHPCF_WORD_RST = 32'h00000000;

endpackage : rhpcf_pkg

/* hw/rhpcf_port.sv */
`timescale 1ns/1ps
module rhpcf_port
  import rhpcf_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RHPCF_RESET_CYCLES,
  parameter int unsigned RESYNC_CYCLES = RHPCF_RESYNC_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // applied driver write
  input wire logic apply,
  input wire logic [31:0] wbits,
  // port state
  input wire logic per_port_oc,
  input wire logic attached_level,
  input wire logic port_overcurrent_level,
  input wire logic resume_signal_done,
  input wire logic hw_disable_evt,
  // results
  output logic [RHPCF_FLAG_W-1:0] flags,
  output logic reset_drive,
  output logic port_on_pulse,
  output logic sleep_pulse,
  output logic reset_end,
  output logic resume_end
);

  localparam int unsigned RCW = $clog2(RESET_CYCLES + 1);
  localparam int unsigned SCW = $clog2(RESYNC_CYCLES + 1);
  localparam logic [RCW-1:0] RESET_LOAD = RCW'(RESET_CYCLES - 1);
  localparam logic [SCW-1:0] RESYNC_LOAD = SCW'(RESYNC_CYCLES - 1);

  logic [RCW-1:0] reset_cnt, next_reset_cnt;
  logic [SCW-1:0] resync_cnt, next_resync_cnt;
  logic resync_busy, next_resync_busy;
  logic next_reset_drive, next_port_on, next_sleep;
  logic attach_q, oc_q;
  logic [RHPCF_FLAG_W-1:0] next_flags;
  logic set_cmd;

  // ---------------------------------------------------------------
  // port reset signalling and resume resync timers
  // ---------------------------------------------------------------
  always_comb begin
    next_reset_cnt = reset_cnt;
    next_reset_drive = reset_drive;
    reset_end = 1'b0;
    if (reset_drive) begin
      if (reset_cnt == '0) begin
        next_reset_drive = 1'b0;
        reset_end = 1'b1; // see R1
      end else begin
        next_reset_cnt = reset_cnt - RCW'(1);
      end
    end else if (apply && wbits[RHPCF_RESET_BIT] && attached_level) begin
      next_reset_drive = 1'b1;
      next_reset_cnt = RESET_LOAD;
    end
    next_resync_cnt = resync_cnt;
    next_resync_busy = resync_busy;
    resume_end = 1'b0;
    if (resync_busy) begin
      if (resync_cnt == '0) begin
        next_resync_busy = 1'b0;
        resume_end = 1'b1; // see R5
      end else begin
        next_resync_cnt = resync_cnt - SCW'(1);
      end
    end else if (resume_signal_done) begin
      next_resync_busy = 1'b1;
      next_resync_cnt = RESYNC_LOAD;
    end
    next_port_on = apply && wbits[RHPCF_ENABLED_BIT] && attached_level;
    next_sleep = apply && wbits[RHPCF_SLEEP_BIT] && attached_level;
  end

  // ---------------------------------------------------------------
  // change flags: set wins over a write-one clear
  // ---------------------------------------------------------------
  always_comb begin
    set_cmd = apply && !attached_level && (wbits[RHPCF_RESET_BIT] ||
      wbits[RHPCF_ENABLED_BIT] || wbits[RHPCF_SLEEP_BIT]);
    next_flags = flags;
    if (apply) begin
      for (int i = 0; i < RHPCF_FLAG_W; i++) begin
        if (wbits[RHPCF_FLAG_BASE + i]) begin
          next_flags[i] = 1'b0; // see R2
        end
      end
    end
    if (reset_end) begin
      next_flags[RHPCF_F_RESET] = 1'b1; // see R1
      next_flags[RHPCF_F_RESUME] = 1'b0; // see R6
    end else if (resume_end) begin
      next_flags[RHPCF_F_RESUME] = 1'b1; // see R5
    end
    if (per_port_oc && (port_overcurrent_level != oc_q)) begin
      next_flags[RHPCF_F_OC] = 1'b1; // see R3
    end
    if (!per_port_oc) begin
      next_flags[RHPCF_F_OC] = 1'b0; // see R4
    end
    if (hw_disable_evt) begin
      next_flags[RHPCF_F_ENABLE] = 1'b1; // see R7
    end
    if ((attached_level != attach_q) || set_cmd) begin
      next_flags[RHPCF_F_ATTACH] = 1'b1; // see R9 see R10
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= RHPCF_FLAGS_RST; // see R14
      reset_cnt <= '0;
      reset_drive <= 1'b0;
      resync_cnt <= '0;
      resync_busy <= 1'b0;
      port_on_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
      attach_q <= 1'b0;
      oc_q <= 1'b0;
    end else begin
      flags <= next_flags;
      reset_cnt <= next_reset_cnt;
      reset_drive <= next_reset_drive;
      resync_cnt <= next_resync_cnt;
      resync_busy <= next_resync_busy;
      port_on_pulse <= next_port_on;
      sleep_pulse <= next_sleep;
      attach_q <= attached_level;
      oc_q <= port_overcurrent_level;
    end
  end

endmodule : rhpcf_port

/* hw/rhpcf_top.sv */
// Behaviour
// R1: the reset-done flag is set when the 10 ms port reset signalling ends.
// R2: a change flag clears when the driver writes one to it; writing zero leaves it.
// R3: the over-current change flag is set whenever the indicator changes; the code sets it only while per_port_oc is high.
// R4: the over-current change flag means something only per-port.
// R5: the resume-done flag is set after resume pulse, end and 3 ms resync.
// R6: the resume-done flag is cleared when the reset-done flag is set.
// R7: the enable change flag is set when hardware clears the port enable.
// R8: driver writes that change the enable never set the enable flag.
// R9: the attach change flag is set on every attach or detach.
// R10: a reset, enable or sleep write to a detached port sets attach change.
// R11: a status write during a bus transaction waits until it completes.
// R12: ports are read with codes 15h and 16h, written with 95h and 96h.
// R13: the driver writes zero to reserved bits.
// R14: each port keeps its own flags, all zero after reset.
`timescale 1ns/1ps
module rhpcf_top
  import rhpcf_pkg::*;
#(
  parameter int unsigned NPORTS = RHPCF_MAX_PORTS,
  parameter int unsigned RESET_CYCLES = RHPCF_RESET_CYCLES,
  parameter int unsigned RESYNC_CYCLES = RHPCF_RESYNC_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command port
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // bus activity
  input wire logic xact_busy,
  // hub configuration
  input wire logic per_port_oc,
  // port status from the port logic
  input wire logic [NPORTS-1:0] attached_level,
  input wire logic [NPORTS-1:0] port_enabled_level,
  input wire logic [NPORTS-1:0] port_overcurrent_level,
  input wire logic [NPORTS-1:0] resume_signal_done,
  input wire logic [NPORTS-1:0] hw_disable_evt,
  // commands to the port logic
  output logic [NPORTS-1:0] port_reset_drive,
  output logic [NPORTS-1:0] cmd_port_on,
  output logic [NPORTS-1:0] cmd_port_sleep
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (NPORTS < 1 || NPORTS > RHPCF_MAX_PORTS) begin : g_bad_ports
    $error("NPORTS must be 1 or 2");
  end
  if (RESET_CYCLES < 1 || RESYNC_CYCLES < 1) begin : g_bad_cycles
    $error("timer cycle counts must be at least one");
  end

  // ---------------------------------------------------------------
  // per-port decode, deferral and flag cells
  // ---------------------------------------------------------------
  logic [NPORTS-1:0] wr_hit;
  logic [NPORTS-1:0] rd_hit;
  logic [NPORTS-1:0] apply;
  logic [NPORTS-1:0] pend_valid;
  logic [NPORTS-1:0] reset_end;
  logic [NPORTS-1:0] resume_end;
  logic [31:0] apply_bits [NPORTS];
  logic [31:0] pend_bits [NPORTS];
  logic [RHPCF_FLAG_W-1:0] flags [NPORTS];

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic next_pend_valid;
    logic [31:0] next_pend_bits;
    logic [31:0] eff_bits;
    logic eff_valid;

    always_comb begin
      wr_hit[p] = cmd_valid &&
        (cmd_code == RHPCF_WR_CODE_BASE + 8'(p)); // see R12
      rd_hit[p] = cmd_valid &&
        (cmd_code == RHPCF_RD_CODE_BASE + 8'(p)); // see R12
      eff_valid = wr_hit[p] || pend_valid[p];
      eff_bits = pend_bits[p] | (wr_hit[p] ? cmd_wdata : RHPCF_WORD_RST);
      // writes meeting a busy bus merge into the pending word
      apply[p] = eff_valid && !xact_busy; // see R11
      apply_bits[p] = apply[p] ? eff_bits : RHPCF_WORD_RST;
      next_pend_valid = eff_valid && xact_busy; // see R11
      next_pend_bits = xact_busy ? eff_bits : RHPCF_WORD_RST;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
        pend_valid[p] <= 1'b0;
        pend_bits[p] <= RHPCF_WORD_RST;
      end else begin
        pend_valid[p] <= next_pend_valid;
        pend_bits[p] <= next_pend_bits;
      end
    end

    // enable changes from writes only pulse the port logic
    rhpcf_port #(
      .RESET_CYCLES(RESET_CYCLES),
      .RESYNC_CYCLES(RESYNC_CYCLES)
    ) u_port (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .apply(apply[p]),
      .wbits(apply_bits[p]),
      .per_port_oc(per_port_oc),
      .attached_level(attached_level[p]),
      .port_overcurrent_level(port_overcurrent_level[p]),
      .resume_signal_done(resume_signal_done[p]),
      .hw_disable_evt(hw_disable_evt[p]), // see R8
      .flags(flags[p]),
      .reset_drive(port_reset_drive[p]),
      .port_on_pulse(cmd_port_on[p]),
      .sleep_pulse(cmd_port_sleep[p]),
      .reset_end(reset_end[p]),
      .resume_end(resume_end[p])
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    sequence s_set_cmd_detached;
      apply[p] && !attached_level[p] &&
        (apply_bits[p][RHPCF_RESET_BIT] || apply_bits[p][RHPCF_ENABLED_BIT]
        || apply_bits[p][RHPCF_SLEEP_BIT]);
    endsequence

    sequence s_attach_clear;
      apply[p] && apply_bits[p][RHPCF_FLAG_BASE + RHPCF_F_ATTACH] &&
        !$changed(attached_level[p]);
    endsequence

    reset_done_set_a: assert property ( // see R1
      @(posedge mclk) disable iff (sys_rst)
      $fell(port_reset_drive[p]) |-> flags[p][RHPCF_F_RESET])
      else $error("reset-done flag not set at end of port reset");

    reset_one_clear_a: assert property ( // see R2
      @(posedge mclk) disable iff (sys_rst)
      apply[p] && apply_bits[p][RHPCF_FLAG_BASE + RHPCF_F_RESET] &&
        !reset_end[p] |=> !flags[p][RHPCF_F_RESET])
      else $error("reset-done flag not cleared by write of one");

    attach_hold_a: assert property ( // see R2
      @(posedge mclk) disable iff (sys_rst)
      flags[p][RHPCF_F_ATTACH] && !(apply[p] &&
        apply_bits[p][RHPCF_FLAG_BASE + RHPCF_F_ATTACH])
        |=> flags[p][RHPCF_F_ATTACH])
      else $error("attach change flag lost without a write of one");

    oc_change_a: assert property ( // see R3
      @(posedge mclk) disable iff (sys_rst)
      per_port_oc && $changed(port_overcurrent_level[p])
        |=> flags[p][RHPCF_F_OC])
      else $error("over-current change not flagged");

    oc_global_zero_a: assert property ( // see R4
      @(posedge mclk) disable iff (sys_rst)
      !per_port_oc |=> !flags[p][RHPCF_F_OC])
      else $error("over-current change flag set in global mode");

    resume_timed_a: assert property ( // see R5
      @(posedge mclk) disable iff (sys_rst)
      $rose(flags[p][RHPCF_F_RESUME]) |-> $past(resume_end[p]))
      else $error("resume-done flag set before resync delay ended");

    resume_wiped_a: assert property ( // see R6
      @(posedge mclk) disable iff (sys_rst)
      reset_end[p] |=> !flags[p][RHPCF_F_RESUME] &&
        flags[p][RHPCF_F_RESET])
      else $error("resume-done flag survived reset completion");

    enable_change_a: assert property ( // see R7
      @(posedge mclk) disable iff (sys_rst)
      hw_disable_evt[p] |=> flags[p][RHPCF_F_ENABLE])
      else $error("hardware disable not flagged");

    enable_write_a: assert property ( // see R8
      @(posedge mclk) disable iff (sys_rst)
      !hw_disable_evt[p] && !flags[p][RHPCF_F_ENABLE]
        |=> !flags[p][RHPCF_F_ENABLE])
      else $error("enable change flag set without hardware event");

    attach_edge_a: assert property ( // see R9
      @(posedge mclk) disable iff (sys_rst)
      $changed(attached_level[p]) |=> flags[p][RHPCF_F_ATTACH])
      else $error("attach or detach not flagged");

    detached_cmd_a: assert property ( // see R10
      @(posedge mclk) disable iff (sys_rst)
      s_set_cmd_detached |=> flags[p][RHPCF_F_ATTACH] &&
        !cmd_port_on[p] && !cmd_port_sleep[p])
      else $error("command to detached port not flagged");

    attach_clear_a: assert property ( // see R2
      @(posedge mclk) disable iff (sys_rst)
      s_attach_clear ##0 (attached_level[p] ||
        !(apply_bits[p][RHPCF_RESET_BIT] || apply_bits[p][RHPCF_ENABLED_BIT]
        || apply_bits[p][RHPCF_SLEEP_BIT])) |=> !flags[p][RHPCF_F_ATTACH])
      else $error("attach change flag not cleared");

    write_defer_a: assert property ( // see R11
      @(posedge mclk) disable iff (sys_rst)
      wr_hit[p] && xact_busy |-> !apply[p] ##1 pend_valid[p])
      else $error("write applied during a bus transaction");

    defer_release_a: assert property ( // see R11
      @(posedge mclk) disable iff (sys_rst)
      pend_valid[p] && !xact_busy |-> apply[p] ##1 !pend_valid[p] ||
        wr_hit[p] && xact_busy)
      else $error("pending write not applied after transaction");

    reset_start_a: assert property ( // see R1
      @(posedge mclk) disable iff (sys_rst)
      apply[p] && apply_bits[p][RHPCF_RESET_BIT] && attached_level[p] &&
        !port_reset_drive[p] |=> port_reset_drive[p])
      else $error("port reset signalling not started");

    reset_refused_a: assert property ( // see R10
      @(posedge mclk) disable iff (sys_rst)
      apply[p] && apply_bits[p][RHPCF_RESET_BIT] && !attached_level[p] &&
        !port_reset_drive[p] |=> !port_reset_drive[p])
      else $error("port reset started on a detached port");

    on_pulse_a: assert property ( // see R8
      @(posedge mclk) disable iff (sys_rst)
      apply[p] && apply_bits[p][RHPCF_ENABLED_BIT] && attached_level[p]
        |=> cmd_port_on[p])
      else $error("enable write not passed to the port");

    enable_hold_a: assert property ( // see R2
      @(posedge mclk) disable iff (sys_rst)
      flags[p][RHPCF_F_ENABLE] && !(apply[p] &&
        apply_bits[p][RHPCF_FLAG_BASE + RHPCF_F_ENABLE])
        |=> flags[p][RHPCF_F_ENABLE])
      else $error("enable change flag lost without a write of one");

    resume_hold_a: assert property ( // see R2
      @(posedge mclk) disable iff (sys_rst)
      flags[p][RHPCF_F_RESUME] && !reset_end[p] && !(apply[p] &&
        apply_bits[p][RHPCF_FLAG_BASE + RHPCF_F_RESUME])
        |=> flags[p][RHPCF_F_RESUME])
      else $error("resume-done flag lost without a write of one");

    oc_hold_a: assert property ( // see R2
      @(posedge mclk) disable iff (sys_rst)
      flags[p][RHPCF_F_OC] && per_port_oc && !(apply[p] &&
        apply_bits[p][RHPCF_FLAG_BASE + RHPCF_F_OC])
        |=> flags[p][RHPCF_F_OC])
      else $error("over-current change flag lost without a write of one");

    read_port_a: assert property ( // see R12
      @(posedge mclk) disable iff (sys_rst)
      rd_hit[p] |=> rd_valid &&
        rd_data[RHPCF_FLAG_BASE +: RHPCF_FLAG_W] == $past(flags[p]))
      else $error("port read answered with wrong flags");
  end

  // ---------------------------------------------------------------
  // read path: one cycle after the read code
  // ---------------------------------------------------------------
  logic [31:0] next_rd_data;
  logic next_rd_valid;

  always_comb begin
    next_rd_data = RHPCF_WORD_RST;
    next_rd_valid = 1'b0;
    for (int p = 0; p < NPORTS; p++) begin
      if (rd_hit[p]) begin
        next_rd_valid = 1'b1;
        next_rd_data[RHPCF_ATTACHED_BIT] = attached_level[p];
        next_rd_data[RHPCF_ENABLED_BIT] = port_enabled_level[p];
        next_rd_data[RHPCF_OC_LEVEL_BIT] =
          per_port_oc && port_overcurrent_level[p];
        next_rd_data[RHPCF_RESET_BIT] = port_reset_drive[p];
        next_rd_data[RHPCF_FLAG_BASE +: RHPCF_FLAG_W] = flags[p];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= RHPCF_WORD_RST;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  read_answer_a: assert property ( // see R12
    @(posedge mclk) disable iff (sys_rst)
    cmd_valid && cmd_code == RHPCF_RD_CODE_BASE |=> rd_valid &&
      rd_data[RHPCF_FLAG_BASE +: RHPCF_FLAG_W] == $past(flags[0]))
    else $error("port one read answered wrongly");

  read_quiet_a: assert property ( // see R12
    @(posedge mclk) disable iff (sys_rst)
    !(|rd_hit) |=> !rd_valid && rd_data == RHPCF_WORD_RST)
    else $error("read answer without a read code");

endmodule : rhpcf_top

/* verification/rhpcf_dev_model.sv */
`timescale 1ns/1ps
module rhpcf_dev_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // from the root hub
  input wire logic [1:0] port_reset_drive,
  input wire logic [1:0] cmd_port_on,
  // port state
  output logic [1:0] attached_level,
  output logic [1:0] port_enabled_level,
  output logic [1:0] port_overcurrent_level,
  output logic [1:0] resume_signal_done,
  output logic [1:0] hw_disable_evt
);
  logic [1:0] rst_q;

  initial begin
    attached_level = 2'h0;
    port_overcurrent_level = 2'h0;
    resume_signal_done = 2'h0;
    hw_disable_evt = 2'h0;
  end

  // ---------------------------------------------------------------
  // port enable seen by the device
  // ---------------------------------------------------------------
  // enabled when reset signalling ends or on an enable command
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_q <= 2'h0;
      port_enabled_level <= 2'h0;
    end else begin
      rst_q <= port_reset_drive;
      port_enabled_level <= (port_enabled_level | cmd_port_on |
        (rst_q & ~port_reset_drive)) & ~hw_disable_evt & attached_level;
    end
  end

  // ---------------------------------------------------------------
  // events, driven at the falling edge
  // ---------------------------------------------------------------
  task automatic plug(input int p, input logic v);
    @(negedge mclk);
    attached_level[p] = v;
  endtask : plug

  task automatic set_oc(input int p, input logic v);
    @(negedge mclk);
    port_overcurrent_level[p] = v;
  endtask : set_oc

  // sel 0: resume signalling finished, sel 1: hardware fault disable
  task automatic pulse(input int p, input logic sel);
    @(negedge mclk);
    if (sel) hw_disable_evt[p] = 1'b1;
    else resume_signal_done[p] = 1'b1;
    @(negedge mclk);
    hw_disable_evt[p] = 1'b0;
    resume_signal_done[p] = 1'b0;
  endtask : pulse
endmodule : rhpcf_dev_model

/* verification/rhpcf_tb.sv */
`timescale 1ns/1ps
module rhpcf_tb
  import rhpcf_pkg::*;
;
  localparam int unsigned RST_CYC = 20;
  localparam int unsigned SYNC_CYC = 12;
  logic mclk, sys_rst, cmd_valid, xact_busy, per_port_oc, rd_valid;
  logic [7:0] cmd_code;
  logic [31:0] cmd_wdata, rd_data, word;
  logic [1:0] att, ena, ocl, res_done, hw_dis, rst_drv, p_on, p_sleep;
  logic [31:0] cmd_bits [3] = '{32'h00000010, 32'h00000002, 32'h00000004};
  int n_errors, tests_run, k;

  rhpcf_top #(.NPORTS(2), .RESET_CYCLES(RST_CYC),
    .RESYNC_CYCLES(SYNC_CYC)) rhpcf_top_i (
    .mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid), .xact_busy(xact_busy), .per_port_oc(per_port_oc),
    .attached_level(att), .port_enabled_level(ena),
    .port_overcurrent_level(ocl), .resume_signal_done(res_done),
    .hw_disable_evt(hw_dis), .port_reset_drive(rst_drv),
    .cmd_port_on(p_on), .cmd_port_sleep(p_sleep));

  rhpcf_dev_model rhpcf_dev_model_i (
    .mclk(mclk), .sys_rst(sys_rst), .port_reset_drive(rst_drv),
    .cmd_port_on(p_on), .attached_level(att), .port_enabled_level(ena),
    .port_overcurrent_level(ocl), .resume_signal_done(res_done),
    .hw_disable_evt(hw_dis));

  // ---------------------------------------------------------------
  // checks and command port tasks
  // ---------------------------------------------------------------
  task automatic complete_run;
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check_word(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %b", $time, m, got);
    end
  endtask : check_bit

  task automatic hub_write(input logic [7:0] p, input logic [31:0] d);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = RHPCF_WR_CODE_BASE + p;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_wdata = 32'h00000000;
  endtask : hub_write

  task automatic hub_read(input logic [7:0] p, output logic [31:0] d);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = RHPCF_RD_CODE_BASE + p;
    @(negedge mclk);
    cmd_valid = 1'b0;
    check_bit(rd_valid, 1'b1, "read answer");
    d = rd_data;
  endtask : hub_read

  task automatic read_chk(input logic [7:0] p, input logic [31:0] e,
    input string m);
    logic [31:0] d;
    hub_read(p, d);
    check_word(d, e, m);
  endtask : read_chk

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h00000000;
    xact_busy = 1'b0;
    per_port_oc = 1'b1;
    n_errors = 0;
    tests_run = 0;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    read_chk(8'h00, 32'h00000000, "port1 after reset");
    read_chk(8'h01, 32'h00000000, "port2 after reset");
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code = 8'h17;
    @(negedge mclk);
    cmd_valid = 1'b0;
    check_bit(rd_valid, 1'b0, "unknown code answered");
    rhpcf_dev_model_i.plug(0, 1'b1);
    read_chk(8'h00, 32'h00010001, "attach flag");
    read_chk(8'h01, 32'h00000000, "other port touched");
    hub_write(8'h00, 32'h00000000);
    read_chk(8'h00, 32'h00010001, "zero write cleared");
    hub_write(8'h00, 32'h00010000);
    read_chk(8'h00, 32'h00000001, "one write kept");
    // reset, enable and sleep commands to the detached port
    for (int i = 0; i < 3; i++) begin
      hub_write(8'h01, cmd_bits[i]);
      check_bit(rst_drv[1] | p_on[1] | p_sleep[1], 1'b0, "acted");
      read_chk(8'h01, 32'h00010000, "detached command");
      if (i < 2) hub_write(8'h01, 32'h00010000);
    end
    xact_busy = 1'b1;
    hub_write(8'h01, 32'h00010000);
    repeat (3) @(negedge mclk);
    read_chk(8'h01, 32'h00010000, "applied while busy");
    xact_busy = 1'b0;
    @(negedge mclk);
    read_chk(8'h01, 32'h00000000, "not applied after busy");
    rhpcf_dev_model_i.pulse(0, 1'b0);
    // first read samples one edge before the flag, the second one after
    repeat (SYNC_CYC - 3) @(negedge mclk);
    read_chk(8'h00, 32'h00000001, "resume flag early");
    read_chk(8'h00, 32'h00040001, "resume flag");
    hub_write(8'h00, 32'h00000010);
    for (k = 0; k < RST_CYC + 4 && rst_drv[0]; k++) @(negedge mclk);
    if (rst_drv[0] !== 1'b0) begin
      n_errors++;
      complete_run();
    end
    check_word(32'(k), 32'(RST_CYC), "reset length");
    read_chk(8'h00, 32'h00100003, "reset done");
    hub_write(8'h00, 32'h00100000);
    read_chk(8'h00, 32'h00000003, "reset flag clear");
    rhpcf_dev_model_i.pulse(0, 1'b1);
    read_chk(8'h00, 32'h00020001, "hardware disable");
    hub_write(8'h00, 32'h00020000);
    hub_write(8'h00, 32'h00000002);
    check_bit(p_on[0], 1'b1, "enable pulse");
    read_chk(8'h00, 32'h00000003, "driver enable");
    hub_write(8'h00, 32'h00000004);
    check_bit(p_sleep[0], 1'b1, "sleep pulse");
    rhpcf_dev_model_i.set_oc(0, 1'b1);
    read_chk(8'h00, 32'h0008000B, "overcurrent change");
    hub_write(8'h00, 32'h00080000);
    per_port_oc = 1'b0;
    rhpcf_dev_model_i.set_oc(0, 1'b0);
    read_chk(8'h00, 32'h00000003, "global overcurrent");
    rhpcf_dev_model_i.plug(0, 1'b0);
    hub_read(8'h00, word);
    check_bit(word[16], 1'b1, "detach flag");
    complete_run();
  end
endmodule : rhpcf_tb
